// >>> bench/chip_select_ready_wait_bench.sv
// self-checking bench for the chip-select unit
// assumes the ready model as the far side and inputs driven on falling edges
`timescale 1ns/1ps
module chip_select_ready_wait_bench;
  import csu_pkg::*;
  logic ref_clk_i, rst_i, cycle_start_i, cycle_is_io_i, ctl_wr_i, ram_en_i;
  logic [ADDR_W-1:0] cycle_addr_i;
  logic [2:0] ctl_sel_i;
  logic [CTL_W-1:0] ctl_data_i;
  logic [4:0] ram_base_i;
  logic [7:0] regblk_base_i, delay;
  logic async_rdy, sync_rdy, use_sync, up_n, lo_n, ram_s, regblk_s, ade, ws, ce;
  logic [3:0] mid_n, lp_n;
  logic [1:0] upp_n;
  logic [4:0] snap1;
  logic [9:0] snap2;
  int n_errors = 0;
  int checks = 0;
  int l1, l2, nw;
  int pw[8] = '{0, 1, 2, 3, 5, 7, 9, 15};

  chip_select_ready_wait dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cycle_start_i(cycle_start_i), .cycle_addr_i(cycle_addr_i), .cycle_is_io_i(cycle_is_io_i),
    .ctl_wr_i(ctl_wr_i), .ctl_sel_i(ctl_sel_i), .ctl_data_i(ctl_data_i), .ram_en_i(ram_en_i),
    .ram_base_i(ram_base_i), .regblk_base_i(regblk_base_i), .async_ready_in_i(async_rdy),
    .sync_ready_in_i(sync_rdy), .upper_region_select_n_o(up_n), .lower_region_select_n_o(lo_n),
    .midrange_region_selects_n_o(mid_n), .lower_peripheral_selects_n_o(lp_n),
    .upper_peripheral_selects_n_o(upp_n), .ram_select_o(ram_s), .regblk_select_o(regblk_s),
    .addr_drive_en_o(ade), .wait_state_o(ws), .cycle_end_o(ce));

  ready_model ready_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .delay_i(delay),
    .use_sync_i(use_sync), .sel_n_i({up_n, lo_n, mid_n, lp_n, upp_n}),
    .async_ready_o(async_rdy), .sync_ready_o(sync_rdy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_len(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : check_len

  task automatic write_ctl(input logic [2:0] sel, input logic [15:0] data);
    @(negedge ref_clk_i);
    ctl_wr_i = 1'b1;
    ctl_sel_i = sel;
    ctl_data_i = data;
    @(negedge ref_clk_i);
    ctl_wr_i = 1'b0;
  endtask : write_ctl

  // length counts edges from the taking edge to the one that shows the final state
  task automatic bus_cycle(input logic [19:0] addr, input logic io, output int len);
    int k;
    @(negedge ref_clk_i);
    cycle_addr_i = addr;
    cycle_is_io_i = io;
    cycle_start_i = 1'b1;
    @(negedge ref_clk_i);
    cycle_start_i = 1'b0;
    k = 1;
    nw = (ws === 1'b1);
    snap1 = {up_n, lo_n, ade, ram_s, regblk_s};
    while (ce !== 1'b1 && k < 100) begin
      @(negedge ref_clk_i);
      k++;
      nw += (ws === 1'b1);
      if (k == 2) begin
        snap2 = {mid_n, lp_n, upp_n};
      end
    end
    len = k;
  endtask : bus_cycle

  task automatic conclude;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    {rst_i, cycle_start_i, cycle_is_io_i, ctl_wr_i, ram_en_i, use_sync} = 6'h20;
    {cycle_addr_i, ctl_sel_i, ctl_data_i, delay} = '0;
    ram_base_i = 5'h02;
    regblk_base_i = 8'h22;
    repeat (16) @(negedge ref_clk_i);
    check_val("reset outputs", 24'h01FFE0,
              {7'h00, up_n, lo_n, mid_n, lp_n, upp_n, ram_s, regblk_s, ade, ws, ce});
    rst_i = 1'b0;
    bus_cycle(20'hF0000, 1'b0, l1);
    check_len("upper default length", 7, l1);
    check_len("upper default waits", 3, nw);
    check_val("upper first state", 24'h0C, {19'h0, snap1});
    for (int s = 0; s < 2; s++) begin
      use_sync = s[0];
      delay = 8'h0A;
      bus_cycle(20'hFFFF0, 1'b0, l1);
      delay = 8'h0C;
      bus_cycle(20'hFFFF0, 1'b0, l2);
      check_len("late ready step", 2, l2 - l1);
      check_len("late ready stretch", 1, int'(l1 > 7));
    end
    $display("test upper done");
    delay = 8'hFF;
    for (int w = 0; w < 4; w++) begin
      write_ctl(CTL_LOWER, 16'h1004 | 16'(w));
      bus_cycle(20'h00100, 1'b0, l1);
      check_len("lower ignored length", 4 + w, l1);
      check_len("lower waits", w, nw);
      check_val("lower first state", 24'h14, {19'h0, snap1});
    end
    delay = 8'h00;
    write_ctl(CTL_LOWER, 16'h1002);
    bus_cycle(20'h00100, 1'b0, l1);
    check_len("two waits prompt ready", 6, l1);
    write_ctl(CTL_LOWER, 16'h1084);
    bus_cycle(20'h00100, 1'b0, l1);
    check_val("address drive off", 24'h10, {19'h0, snap1});
    $display("test lower done");
    delay = 8'hFF;
    // regions chosen apart so that no two selects share an address
    write_ctl(CTL_LOWER, 16'h1005);
    write_ctl(CTL_MIDPER, 16'h0006);
    for (int c = 0; c < 8; c++) begin
      write_ctl(CTL_PERIPH, 16'h0008 | 16'(c));
      bus_cycle(20'h00000, 1'b1, l1);
      check_len("peripheral wait code", 4 + pw[c], l1);
      check_val("peripheral select", 24'h3FB, {14'h0, snap2});
    end
    bus_cycle(20'h00000, 1'b0, l1);
    check_len("memory zero beside io", 5, l1);
    check_val("no peripheral on memory", 24'h3FF, {14'h0, snap2});
    bus_cycle(20'h00400, 1'b1, l1);
    check_len("fifth select waits", 19, l1);
    check_val("fifth select pins", 24'h3FF, {14'h0, snap2});
    bus_cycle(20'h00500, 1'b1, l1);
    check_len("upper peripheral waits", 6, l1);
    check_val("upper peripheral select", 24'h3FE, {14'h0, snap2});
    // address mode: pins carry addr[2:1], ready demanded by the size word must be dropped
    write_ctl(CTL_MIDPER, 16'h0042);
    bus_cycle(20'h00502, 1'b1, l1);
    check_len("address mode length", 4, l1);
    check_val("address mode pins", 24'h3FD, {14'h0, snap2});
    write_ctl(CTL_MIDPER, 16'h0006);
    $display("test peripheral done");
    write_ctl(CTL_MID, 16'h4005);
    bus_cycle(20'h46000, 1'b0, l1);
    check_len("midrange length", 5, l1);
    check_len("midrange waits", 1, nw);
    check_val("midrange select", 24'h1FF, {14'h0, snap2});
    $display("test midrange done");
    ram_en_i = 1'b1;
    bus_cycle(20'h10000, 1'b0, l1);
    check_len("ram length", 4, l1);
    check_val("ram select", 24'h02, {22'h0, snap1[1:0]});
    bus_cycle(20'h02200, 1'b1, l1);
    check_len("register block length", 4, l1);
    check_val("register block select", 24'h01, {22'h0, snap1[1:0]});
    $display("test internal done");
    conclude();
  end
endmodule : chip_select_ready_wait_bench

// >>> bench/ready_model.sv
// ready responder for the external memories and peripherals
// assumes active-low selects and one processor clock
`timescale 1ns/1ps
module ready_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // behaviour set by the bench
  input wire logic [7:0] delay_i,
  input wire logic use_sync_i,
  input wire logic [11:0] sel_n_i,
  // ready lines
  output logic async_ready_o,
  output logic sync_ready_o
);
  logic [7:0] cnt;
  logic idle_pat;
  logic hit;

  assign hit = ~&sel_n_i;

  // count cycles since a device was selected; saturates so a slow device never wraps
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !hit) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end

  // nobody drives ready while unselected, so show a level that keeps changing
  always_ff @(posedge ref_clk_i) begin
    idle_pat <= rst_i ? 1'b0 : ~idle_pat;
  end

  always_comb begin
    async_ready_o = hit ? (!use_sync_i && cnt >= delay_i) : idle_pat;
    sync_ready_o = hit ? (use_sync_i && cnt >= delay_i) : ~idle_pat;
  end
endmodule : ready_model

// >>> verilog/chip_select_ready_wait.sv
// chip-select decode with ready sensing and wait-state insertion
// assumes one bus cycle at a time, started by a pulse while idle
//
// Behaviour
// - selects assert for cycles in their region, whoever starts the cycle
// - upper and lower selects assert with the nonmultiplexed address
// - each external control word has a ready-required or ignored bit
// - either async or sync ready input ends or extends the cycle
// - on-chip RAM never samples ready and runs zero waits
// - two-bit wait field, zero to three, for most selects
// - lower peripheral selects add 5, 7, 9 and 15 waits
// - programmed waits finish before ready can end the cycle
// - two waits, ready at first wait: cycle is base plus two
// - ready late: extend until ready, then exactly one more wait
// - register block and RAM selects are zero-wait, ready-ignored
// - address-drive-disable suppresses muxed address when select asserts
// - midrange/peripheral timing stays active even when pins are PIO
// - fifth peripheral select keeps timing logic without a pin
// - upper peripheral pins as address bits drop their timing
// - mismatched overlap may wait for ready forever
// - overlap means several selects on one physical address
// - after reset upper select covers top 64K, ready, three waits
// - peripheral selects inactive after reset until programmed
`timescale 1ns/1ps
module chip_select_ready_wait
  import csu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // bus cycle request
  input wire logic cycle_start_i,
  input wire logic [ADDR_W-1:0] cycle_addr_i,
  input wire logic cycle_is_io_i,
  // control word writes
  input wire logic ctl_wr_i,
  input wire logic [2:0] ctl_sel_i,
  input wire logic [CTL_W-1:0] ctl_data_i,
  // internal selects
  input wire logic ram_en_i,
  input wire logic [4:0] ram_base_i,
  input wire logic [7:0] regblk_base_i,
  // ready inputs
  input wire logic async_ready_in_i,
  input wire logic sync_ready_in_i,
  // select pins, active low
  output logic upper_region_select_n_o,
  output logic lower_region_select_n_o,
  output logic [3:0] midrange_region_selects_n_o,
  output logic [3:0] lower_peripheral_selects_n_o,
  output logic [1:0] upper_peripheral_selects_n_o,
  // internal selects
  output logic ram_select_o,
  output logic regblk_select_o,
  // bus timing
  output logic addr_drive_en_o,
  output logic wait_state_o,
  output logic cycle_end_o
);

  ////////////////////////////////////////////////////////////////////////
  // control words

  logic [CTL_W-1:0] upper_select_control;
  logic [CTL_W-1:0] lower_select_control;
  logic [CTL_W-1:0] midrange_base_control;
  logic [CTL_W-1:0] peripheral_base_control;
  logic [CTL_W-1:0] midrange_peripheral_size_control;
  logic lower_en;
  logic mid_wr;
  logic per_wr;
  logic mp_wr;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      upper_select_control <= UPPER_CTL_RST;
      lower_select_control <= CTL_RST;
      midrange_base_control <= CTL_RST;
      peripheral_base_control <= CTL_RST;
      midrange_peripheral_size_control <= CTL_RST;
    end else if (ctl_wr_i) begin
      unique case (ctl_sel_i)
        CTL_UPPER: upper_select_control <= ctl_data_i;
        CTL_LOWER: lower_select_control <= ctl_data_i;
        CTL_MID: midrange_base_control <= ctl_data_i;
        CTL_PERIPH: peripheral_base_control <= ctl_data_i;
        CTL_MIDPER: midrange_peripheral_size_control <= ctl_data_i;
        default: ;
      endcase
    end
  end

  // lower, midrange and peripheral regions come alive only once their control words were written
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lower_en <= 1'b0;
      mid_wr <= 1'b0;
      per_wr <= 1'b0;
      mp_wr <= 1'b0;
    end else if (ctl_wr_i) begin
      if (ctl_sel_i == CTL_LOWER) begin
        lower_en <= 1'b1;
      end
      if (ctl_sel_i == CTL_MID) begin
        mid_wr <= 1'b1;
      end
      if (ctl_sel_i == CTL_PERIPH) begin
        per_wr <= 1'b1;
      end
      if (ctl_sel_i == CTL_MIDPER) begin
        mp_wr <= 1'b1;
      end
    end
  end

  logic mid_en;
  logic per_en;
  logic as_addr;
  logic per_in_mem;

  // enables do not depend on the pin function (chip select or PIO)
  assign mid_en = mid_wr & mp_wr;
  assign per_en = per_wr & mp_wr;
  assign as_addr = midrange_peripheral_size_control[F_AS_ADDR];
  assign per_in_mem = midrange_peripheral_size_control[F_IN_MEM];

  ////////////////////////////////////////////////////////////////////////
  // address decode; the initiator (CPU or DMA) plays no part

  logic mem;
  logic hit_upper;
  logic hit_lower;
  logic hit_mid_blk;
  logic hit_per_blk;
  logic [3:0] hit_mid;
  logic [6:0] hit_per;
  logic hit_ram;
  logic hit_regblk;
  logic [7:0] page;

  assign mem = ~cycle_is_io_i;
  assign page = cycle_addr_i[19:12];
  assign hit_upper = mem && page >= upper_select_control[15:F_BOUND_LSB];
  assign hit_lower = mem && lower_en
                     && page < lower_select_control[15:F_BOUND_LSB];
  assign hit_mid_blk = mid_en && mem
                       && cycle_addr_i[19:15] == midrange_base_control[15:F_MID_BASE_LSB];
  // an I/O peripheral block never meets a memory region at 0
  assign hit_per_blk = per_en && (per_in_mem == mem)
                       && cycle_addr_i[19:11]
                          == peripheral_base_control[15:F_PER_BASE_LSB];
  assign hit_mid = hit_mid_blk ? (4'h1 << cycle_addr_i[14:13]) : 4'h0;
  assign hit_per = hit_per_blk ? 7'(7'h01 << cycle_addr_i[10:8]) : 7'h00;
  assign hit_ram = ram_en_i && mem && cycle_addr_i[19:15] == ram_base_i;
  assign hit_regblk = cycle_is_io_i && cycle_addr_i[19:16] == REGBLK_HI
                      && cycle_addr_i[15:8] == regblk_base_i;

  ////////////////////////////////////////////////////////////////////////
  // merged wait and ready settings of all selects that hit

  logic [WAIT_W-1:0] next_wait;
  logic next_rdy;

  // differing overlaps take the longest wait and any ready demand,
  // so a mismatch can stall on ready forever
  always_comb begin
    next_wait = 4'h0;
    next_rdy = 1'b0;
    if (hit_upper) begin
      next_wait = wmax(next_wait, {2'b00, upper_select_control[1:F_WAIT_LSB]});
      next_rdy = next_rdy | ~upper_select_control[F_RDY_IGN];
    end
    if (hit_lower) begin
      next_wait = wmax(next_wait, {2'b00, lower_select_control[1:F_WAIT_LSB]});
      next_rdy = next_rdy | ~lower_select_control[F_RDY_IGN];
    end
    if (hit_mid_blk) begin
      next_wait = wmax(next_wait, {2'b00, midrange_base_control[1:F_WAIT_LSB]});
      next_rdy = next_rdy | ~midrange_base_control[F_RDY_IGN];
    end
    // the fifth select has no pin but still times its cycles
    if (hit_per_blk && cycle_addr_i[10:8] <= PER_FIFTH) begin
      next_wait = wmax(next_wait, per_wait(peripheral_base_control[2:0]));
      next_rdy = next_rdy | ~peripheral_base_control[F_PRDY_IGN];
    end
    if (hit_per_blk && cycle_addr_i[10:8] >= PER_UPPER0 && !as_addr) begin
      next_wait = wmax(next_wait,
                       {2'b00, midrange_peripheral_size_control[1:F_WAIT_LSB]});
      next_rdy = next_rdy | ~midrange_peripheral_size_control[F_RDY_IGN];
    end
    // RAM and register block add nothing: zero waits, no ready
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer

  bus_state_t state;
  bus_state_t next_state;
  logic take;
  logic [WAIT_W-1:0] wait_q;
  logic rdy_q;
  logic rdy_ok;
  logic [WAIT_W-1:0] rem;

  assign take = (state == S_IDLE) && cycle_start_i;
  assign rdy_ok = async_ready_in_i | sync_ready_in_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wait_q <= 4'h0;
      rdy_q <= 1'b0;
    end else if (take) begin
      wait_q <= next_wait;
      rdy_q <= next_rdy;
    end
  end

  // ready is looked at only one cycle before the last wait or t4
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (cycle_start_i) next_state = S_T1;
      S_T1: next_state = S_T2;
      S_T2: next_state = S_T3;
      S_T3: begin
        if (wait_q > 4'h1) begin
          next_state = S_TW;
        end else if (rdy_q && !rdy_ok) begin
          next_state = S_TRDY;
        end else begin
          next_state = (wait_q == 4'h1) ? S_TW : S_T4;
        end
      end
      S_TW: begin
        if (rem <= 4'h1) begin
          next_state = S_T4;
        end else if (rem == 4'h2 && rdy_q && !rdy_ok) begin
          next_state = S_TRDY;
        end
      end
      S_TRDY: if (rdy_ok) next_state = S_TW;
      S_T4: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // after a late ready exactly one wait remains
  wait_counter u_wait (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(take || (state == S_TRDY && rdy_ok)),
    .load_val_i(take ? next_wait : 4'h1),
    .dec_i(state == S_TW),
    .rem_o(rem)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cycle_end_o <= 1'b0;
      wait_state_o <= 1'b0;
    end else begin
      cycle_end_o <= next_state == S_T4;
      wait_state_o <= next_state == S_TW || next_state == S_TRDY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // select pins

  logic [3:0] mid_q;
  logic [6:0] per_q;
  logic [1:0] a21_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mid_q <= 4'h0;
      per_q <= 7'h00;
      a21_q <= 2'h0;
    end else if (take) begin
      mid_q <= hit_mid;
      per_q <= hit_per;
      a21_q <= cycle_addr_i[2:1];
    end
  end

  // upper and lower go out with the nonmultiplexed address at start
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      upper_region_select_n_o <= 1'b1;
      lower_region_select_n_o <= 1'b1;
      ram_select_o <= 1'b0;
      regblk_select_o <= 1'b0;
    end else if (take) begin
      upper_region_select_n_o <= ~hit_upper;
      lower_region_select_n_o <= ~hit_lower;
      ram_select_o <= hit_ram;
      regblk_select_o <= hit_regblk;
    end else if (next_state == S_IDLE) begin
      upper_region_select_n_o <= 1'b1;
      lower_region_select_n_o <= 1'b1;
      ram_select_o <= 1'b0;
      regblk_select_o <= 1'b0;
    end
  end

  // midrange and peripheral selects follow with the muxed address
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      midrange_region_selects_n_o <= 4'hF;
      lower_peripheral_selects_n_o <= 4'hF;
      upper_peripheral_selects_n_o <= 2'h3;
    end else if (state == S_T1) begin
      midrange_region_selects_n_o <= ~mid_q;
      lower_peripheral_selects_n_o <= ~per_q[3:0];
      upper_peripheral_selects_n_o <= as_addr ? a21_q : ~per_q[6:5];
    end else if (next_state == S_IDLE) begin
      midrange_region_selects_n_o <= 4'hF;
      lower_peripheral_selects_n_o <= 4'hF;
      upper_peripheral_selects_n_o <= as_addr ? a21_q : 2'h3;
    end
  end

  // the muxed bus carries the address in t1 unless a disabling select hits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_drive_en_o <= 1'b0;
    end else if (take) begin
      addr_drive_en_o <= ~((hit_upper && upper_select_control[F_ADDR_DIS])
                           || (hit_lower && lower_select_control[F_ADDR_DIS]));
    end else begin
      addr_drive_en_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_two_wait_ready;
    state == S_T1 && wait_q == 4'h2 && rdy_q ##3 rdy_ok;
  endsequence

  sequence s_late_ready;
    state == S_TRDY && rdy_ok;
  endsequence

  a_two_wait_end: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_two_wait_ready |-> ##2 state == S_T4)
    else $error("two-wait ready cycle did not end after six cycles");

  a_late_one_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_late_ready |=> state == S_TW && rem == 4'h1 ##1 state == S_T4)
    else $error("late ready was not followed by exactly one wait");

  a_waits_first: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(state == S_TRDY) |-> $past(state == S_T3 && wait_q <= 4'h1)
                               || $past(state == S_TW && rem == 4'h2))
    else $error("ready wait entered before programmed waits");

  a_ignore_no_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state == S_TRDY |-> rdy_q)
    else $error("ready held a cycle whose regions ignore ready");

  a_ram_zero_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && hit_ram && !hit_upper && !hit_lower && !hit_mid_blk && !hit_per_blk
    |-> ##4 state == S_T4)
    else $error("on-chip RAM cycle was not zero-wait");

  a_upper_early: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && hit_upper |=> !upper_region_select_n_o && state == S_T1)
    else $error("upper select missed the address phase");

  a_addr_disable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && hit_lower && lower_select_control[F_ADDR_DIS] |=> !addr_drive_en_o)
    else $error("address driven although lower region disables it");

  a_pins_addr_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && hit_per_blk && cycle_addr_i[10:8] >= PER_UPPER0 && as_addr
    && !hit_upper && !hit_lower && !hit_mid_blk |=> wait_q == 4'h0 && !rdy_q)
    else $error("upper peripheral timing active in address mode");

  a_reset_upper: assert property (@(posedge ref_clk_i)
    rst_i |=> upper_select_control[1:0] == 2'h3 && !upper_select_control[F_RDY_IGN]
              && upper_select_control[15:8] == 8'hF0)
    else $error("upper select reset settings wrong");

endmodule : chip_select_ready_wait

// >>> verilog/csu_pkg.sv
// constants shared by the chip-select unit and its wait counter
// assumes one processor clock and a synchronous active-high reset
package csu_pkg;

  localparam int ADDR_W = 20;
  localparam int CTL_W = 16;
  localparam int WAIT_W = 4;

  // control word targets for ctl_wr_i
  typedef enum logic [2:0] {
    CTL_UPPER = 3'h0,
    CTL_LOWER = 3'h1,
    CTL_MID = 3'h2,
    CTL_PERIPH = 3'h3,
    CTL_MIDPER = 3'h4
  } ctl_sel_t;

  // field positions inside the control words
  localparam int F_WAIT_LSB = 0;
  localparam int F_RDY_IGN = 2;
  localparam int F_PRDY_IGN = 3;
  localparam int F_AS_ADDR = 6;
  localparam int F_ADDR_DIS = 7;
  localparam int F_IN_MEM = 7;
  localparam int F_BOUND_LSB = 8;
  localparam int F_MID_BASE_LSB = 11;
  localparam int F_PER_BASE_LSB = 7;

  // upper region: F0000h-FFFFFh, ready required, three waits
  localparam logic [15:0] UPPER_CTL_RST = 16'hF003;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // peripheral index of the fifth select and first upper one
  localparam logic [2:0] PER_FIFTH = 3'h4;
  localparam logic [2:0] PER_UPPER0 = 3'h5;
  localparam logic [3:0] REGBLK_HI = 4'h0;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_T1 = 7'h02,
    S_T2 = 7'h04,
    S_T3 = 7'h08,
    S_TW = 7'h10,
    S_TRDY = 7'h20,
    S_T4 = 7'h40
  } bus_state_t;

  // three-bit wait field of the lower peripheral selects
  function automatic logic [3:0] per_wait(input logic [2:0] code);
    unique case (code)
      3'h4: per_wait = 4'h5;
      3'h5: per_wait = 4'h7;
      3'h6: per_wait = 4'h9;
      3'h7: per_wait = 4'hF;
      default: per_wait = {1'b0, code};
    endcase
  endfunction : per_wait

  function automatic logic [3:0] wmax(input logic [3:0] a, input logic [3:0] b);
    wmax = (a > b) ? a : b;
  endfunction : wmax

endpackage : csu_pkg

// >>> verilog/wait_counter.sv
// down counter of the wait states still to run in a bus cycle
// assumes load and decrement are never asked in the same cycle
`timescale 1ns/1ps
module wait_counter
  import csu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [WAIT_W-1:0] load_val_i,
  input wire logic dec_i,
  // state
  output logic [WAIT_W-1:0] rem_o
);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rem_o <= 4'h0;
    end else if (load_i) begin
      rem_o <= load_val_i;
    end else if (dec_i && rem_o != 4'h0) begin
      rem_o <= rem_o - 4'h1;
    end
  end

endmodule : wait_counter
